// File: logic/clock_gen_pkg.sv
`default_nettype none

package clock_gen_pkg;

    // register offsets (7-bit byte offsets of the management bus command code)
    localparam logic [6:0] OFS_SIGNATURE = 7'h08;
    localparam logic [6:0] OFS_PERIPH_A = 7'h09;
    localparam logic [6:0] OFS_PERIPH_B = 7'h0A;
    localparam logic [6:0] OFS_SKEW_RATIO = 7'h0B;
    localparam logic [6:0] OFS_WATCHDOG = 7'h0C;

    // reset values
    localparam logic [7:0] RST_PERIPH_A = 8'hB8;
    localparam logic [7:0] RST_PERIPH_B = 8'hFF;
    localparam logic [7:0] RST_SKEW_RATIO = 8'h00;
    localparam logic [7:0] RST_WATCHDOG = 8'h80;
    // identity value, arbitrary
    localparam logic [7:0] SIGNATURE_DEFAULT = 8'h5A;

    // peripheral_control_a fields
    localparam int PA_PD_DISABLE = 7;
    localparam int PA_STOP_HIZ = 6;
    localparam int PA_FIXED_EN = 5;
    localparam int PA_SEL_EN = 4;
    localparam int PA_SEL_48 = 3;
    localparam int PA_SPREAD_HI = 2;
    localparam int PA_SPREAD_LO = 0;

    // peripheral_control_b fields
    localparam int PB_MEMORY_EN = 7;
    localparam int PB_REF_HI = 6;
    localparam int PB_REF_LO = 4;
    localparam int PB_LINK_HI = 3;
    localparam int PB_LINK_LO = 2;
    localparam int PB_GFX_HI = 1;
    localparam int PB_GFX_LO = 0;

    // skew_and_ratio_control fields
    localparam int SR_MEM_HI = 7;
    localparam int SR_MEM_LO = 5;
    localparam int SR_GFX_HI = 4;
    localparam int SR_GFX_LO = 2;
    localparam int SR_SKEW_HI = 1;
    localparam int SR_SKEW_LO = 0;

    // watchdog_time_stamp fields
    localparam int WD_PIN_IS_STOP = 7;
    localparam int WD_REVERT_SW = 6;
    localparam int WD_TEST = 5;
    localparam int WATCHDOG_ALARM_FLAG = 4;
    localparam int WD_PERIOD_HI = 3;
    localparam int WD_PERIOD_LO = 0;

    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int WD_SECOND_S = 1;
    localparam int WD_SECOND_CYCLES = CLK_HZ * WD_SECOND_S;
    localparam int RESET_PULSE_NS = 1600;
    localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int SKEW_STEP_PS = 150;

    // per-output run/stop levels
    typedef struct packed {
        logic memory;
        logic [1:0] bus_link;
        logic [1:0] graphics;
        logic [2:0] reference;
        logic fixed_peripheral;
        logic selectable_peripheral;
    } clk_enables_s;

endpackage

`default_nettype wire

// File: logic/watchdog_timer.sv
`timescale 1ns/1ps
`default_nettype none

module watchdog_timer #(
    parameter int SEC_CYCLES = 10_000_000
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_restart,
    input wire logic [3:0] i_period,
    output logic o_expire
);
    localparam int PW = $clog2(SEC_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(SEC_CYCLES - 1);

    logic [PW-1:0] pre_q;
    logic [3:0] sec_q;

    // prescaler of whole seconds; a zero period holds everything idle
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pre_q <= '0;
            sec_q <= 4'h0;
            o_expire <= 1'b0;
        end else if (i_ce) begin
            o_expire <= 1'b0;
            if (i_restart || i_period == 4'h0) begin
                pre_q <= '0;
                sec_q <= 4'h0;
            end else if (pre_q == PRE_LAST) begin
                pre_q <= '0;
                if (sec_q == i_period - 4'h1) begin
                    sec_q <= 4'h0;
                    o_expire <= 1'b1;
                end else begin
                    sec_q <= sec_q + 4'h1;
                end
            end else begin
                pre_q <= pre_q + PW'(1);
            end
        end
    end
endmodule

`default_nettype wire

// File: logic/clock_gen_control_regs.sv
// Notes on behaviour
// - power-down pin counts only while the power-down enable bit is 0
// - in power-down, stop bit picks parked high/low pairs or high impedance
// - fixed 48 MHz output forced low while bit 5 is 0
// - selectable output forced low while bit 4 is 0
// - bit 3 selects 24 MHz at 0, 48 MHz at 1
// - bits 2:0 are spread mode; top bit down at 0, center at 1
// - memory, bus-link and graphics clocks stop when their enable is 0
// - reference outputs forced low when their control bit is 0
// - memory ratio code: 0 default, else 2,3,4,5,6,8,9
// - graphics ratio code: 0 default, 6 to 9, then 10 for 101-111
// - peripheral bus clock stays at half the graphics clock
// - skew code steps processor lag by 150 ps
// - shared pin is clock-stop input at bit 7 = 1, reset output at 0
// - after watchdog reboot revert to strap or second-to-last software frequency
// - alarm set on each expiry, cleared when host clears the period
// - period code 0 is off, else that many seconds
// - first expiry pulses reset, sets alarm, restarts timer
// - later expiries also restore the revert frequency, until period cleared or a new frequency is applied
`timescale 1ns/1ps
`default_nettype none

module clock_gen_control_regs #(
    parameter int WD_SECOND_CYCLES = clock_gen_pkg::WD_SECOND_CYCLES,
    parameter logic [7:0] SIGNATURE = clock_gen_pkg::SIGNATURE_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // byte register port behind the management bus
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [6:0] i_addr,
    input wire logic [7:0] i_wr_data,
    output logic [7:0] o_rd_data,
    // pins and clock sources, sampled as synchronous levels
    input wire logic i_power_down_n,
    input wire logic i_reference_src,
    input wire logic i_src_48m,
    input wire logic i_src_24m,
    input wire logic [4:0] i_strap_freq,
    input wire logic i_freq_change,
    input wire logic [4:0] i_new_freq,
    // shared reset / clock-stop pin
    input wire logic i_shared_pin_in,
    output logic o_shared_pin_out,
    output logic o_shared_pin_oe,
    output logic o_periph_clk_stop_n,
    // processor pair parking
    output logic o_power_down,
    output logic o_cpu_true_level,
    output logic o_cpu_comp_level,
    output logic o_cpu_hiz,
    // clocks and settings
    output clock_gen_pkg::clk_enables_s o_clk_en,
    output logic [2:0] o_reference_out,
    output logic o_fixed_peripheral_clk,
    output logic o_selectable_peripheral_clk,
    output logic o_spread_center,
    output logic [2:0] o_spread_mode,
    output logic [3:0] o_memory_ratio,
    output logic [3:0] o_graphics_ratio,
    output logic [4:0] o_periph_bus_ratio,
    output logic [8:0] o_memory_skew_ps,
    output logic [4:0] o_freq_sel,
    output logic o_watchdog_alarm_flag
);
    logic [7:0] periph_a_q;
    logic [7:0] periph_b_q;
    logic [7:0] skew_ratio_q;
    logic [7:0] wd_ctrl_q;
    logic alarm_q;
    logic expired_once_q;
    logic [4:0] cur_sw_q;
    logic [4:0] prev_sw_q;
    logic strap_taken_q;
    logic [7:0] pulse_cnt_q;
    logic wd_expire;
    logic wd_restart;
    logic wr_wd;
    logic [3:0] watchdog_period;

    // ratio decode for the memory divider, 0 means table default
    function automatic logic [3:0] memory_ratio_of(input logic [2:0] code);
        unique case (code)
            3'h0: memory_ratio_of = 4'h0;
            3'h1: memory_ratio_of = 4'h2;
            3'h2: memory_ratio_of = 4'h3;
            3'h3: memory_ratio_of = 4'h4;
            3'h4: memory_ratio_of = 4'h5;
            3'h5: memory_ratio_of = 4'h6;
            3'h6: memory_ratio_of = 4'h8;
            3'h7: memory_ratio_of = 4'h9;
        endcase
    endfunction

    // ratio decode for the graphics divider, 0 means table default
    function automatic logic [3:0] graphics_ratio_of(input logic [2:0] code);
        if (code == 3'h0) begin
            graphics_ratio_of = 4'h0;
        end else if (code >= 3'h5) begin
            graphics_ratio_of = 4'hA;
        end else begin
            graphics_ratio_of = 4'(code) + 4'h5;
        end
    endfunction

    assign watchdog_period = wd_ctrl_q[clock_gen_pkg::WD_PERIOD_HI:clock_gen_pkg::WD_PERIOD_LO];
    assign wr_wd = i_wr_en && i_addr == clock_gen_pkg::OFS_WATCHDOG;
    // timer starts once the new frequency is applied
    assign wd_restart = i_freq_change || (wr_wd && i_wr_data[3:0] != 4'h0);

    watchdog_timer #(
        .SEC_CYCLES(WD_SECOND_CYCLES)
    ) u_timer (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_restart(wd_restart),
        .i_period(watchdog_period),
        .o_expire(wd_expire)
    );

    // control bytes written by the host; the test bit is stored as written
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            periph_a_q <= clock_gen_pkg::RST_PERIPH_A;
            periph_b_q <= clock_gen_pkg::RST_PERIPH_B;
            skew_ratio_q <= clock_gen_pkg::RST_SKEW_RATIO;
            wd_ctrl_q <= clock_gen_pkg::RST_WATCHDOG;
        end else if (i_ce && i_wr_en) begin
            unique case (i_addr)
                clock_gen_pkg::OFS_PERIPH_A: periph_a_q <= i_wr_data;
                clock_gen_pkg::OFS_PERIPH_B: periph_b_q <= i_wr_data;
                clock_gen_pkg::OFS_SKEW_RATIO: skew_ratio_q <= i_wr_data;
                // test bit kept as host writes it
                clock_gen_pkg::OFS_WATCHDOG: wd_ctrl_q <= i_wr_data;
                default: ;
            endcase
        end
    end

    // alarm: expiry wins over a clearing write in the same cycle
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            alarm_q <= 1'b0;
        end else if (i_ce) begin
            // set on expiry, clear with period
            if (wd_expire) begin
                alarm_q <= 1'b1;
            end else if (wr_wd && i_wr_data[3:0] == 4'h0) begin
                alarm_q <= 1'b0;
            end
        end
    end

    // expiry sequence and frequency selection; strap caught after reset release
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            expired_once_q <= 1'b0;
            cur_sw_q <= 5'h00;
            prev_sw_q <= 5'h00;
            o_freq_sel <= 5'h00;
            strap_taken_q <= 1'b0;
        end else if (i_ce) begin
            if (!strap_taken_q) begin
                strap_taken_q <= 1'b1;
                o_freq_sel <= i_strap_freq;
                cur_sw_q <= i_strap_freq;
                prev_sw_q <= i_strap_freq;
            end else if (i_freq_change) begin
                prev_sw_q <= cur_sw_q;
                cur_sw_q <= i_new_freq;
                o_freq_sel <= i_new_freq;
                expired_once_q <= 1'b0;
            end else if (wd_expire) begin
                expired_once_q <= 1'b1;
                if (expired_once_q) begin
                    o_freq_sel <= wd_ctrl_q[clock_gen_pkg::WD_REVERT_SW] ? prev_sw_q : i_strap_freq;
                end
            end else if (wr_wd && i_wr_data[3:0] == 4'h0) begin
                expired_once_q <= 1'b0;
            end
        end
    end

    // low reset pulse width counter, reloaded on every expiry
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pulse_cnt_q <= 8'h00;
        end else if (i_ce) begin
            if (wd_expire) begin
                pulse_cnt_q <= 8'(clock_gen_pkg::RESET_PULSE_CYCLES);
            end else if (pulse_cnt_q != 8'h00) begin
                pulse_cnt_q <= pulse_cnt_q - 8'h01;
            end
        end
    end

    // shared pin direction and the clock-stop level seen by the core
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_shared_pin_oe <= 1'b0;
            o_shared_pin_out <= 1'b1;
            o_periph_clk_stop_n <= 1'b1;
        end else if (i_ce) begin
            o_shared_pin_oe <= !wd_ctrl_q[clock_gen_pkg::WD_PIN_IS_STOP];
            o_shared_pin_out <= pulse_cnt_q == 8'h00;
            o_periph_clk_stop_n <= wd_ctrl_q[clock_gen_pkg::WD_PIN_IS_STOP] ? i_shared_pin_in : 1'b1;
        end
    end

    // power-down and processor pair parking
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_power_down <= 1'b0;
            o_cpu_true_level <= 1'b1;
            o_cpu_comp_level <= 1'b0;
            o_cpu_hiz <= 1'b0;
        end else if (i_ce) begin
            // pin honoured only with enable bit at 0
            o_power_down <= !periph_a_q[clock_gen_pkg::PA_PD_DISABLE] && !i_power_down_n;
            o_cpu_true_level <= 1'b1;
            o_cpu_comp_level <= 1'b0;
            o_cpu_hiz <= periph_a_q[clock_gen_pkg::PA_STOP_HIZ] && !periph_a_q[clock_gen_pkg::PA_PD_DISABLE]
                && !i_power_down_n;
        end
    end

    // gated clock outputs; a stopped output is held low, cut at the next edge even mid-level
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_clk_en <= '0;
            o_reference_out <= 3'h0;
            o_fixed_peripheral_clk <= 1'b0;
            o_selectable_peripheral_clk <= 1'b0;
        end else if (i_ce) begin
            o_clk_en.memory <= periph_b_q[clock_gen_pkg::PB_MEMORY_EN];
            o_clk_en.bus_link <= periph_b_q[clock_gen_pkg::PB_LINK_HI:clock_gen_pkg::PB_LINK_LO];
            o_clk_en.graphics <= periph_b_q[clock_gen_pkg::PB_GFX_HI:clock_gen_pkg::PB_GFX_LO];
            o_clk_en.reference <= periph_b_q[clock_gen_pkg::PB_REF_HI:clock_gen_pkg::PB_REF_LO];
            o_clk_en.fixed_peripheral <= periph_a_q[clock_gen_pkg::PA_FIXED_EN];
            o_clk_en.selectable_peripheral <= periph_a_q[clock_gen_pkg::PA_SEL_EN];
            o_reference_out <= periph_b_q[clock_gen_pkg::PB_REF_HI:clock_gen_pkg::PB_REF_LO] & {3{i_reference_src}};
            o_fixed_peripheral_clk <= periph_a_q[clock_gen_pkg::PA_FIXED_EN] && i_src_48m;
            o_selectable_peripheral_clk <= periph_a_q[clock_gen_pkg::PA_SEL_EN]
                && (periph_a_q[clock_gen_pkg::PA_SEL_48] ? i_src_48m : i_src_24m);
        end
    end

    // divider, skew and spread settings handed to the synthesis core
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_spread_mode <= 3'h0;
            o_spread_center <= 1'b0;
            o_memory_ratio <= 4'h0;
            o_graphics_ratio <= 4'h0;
            o_periph_bus_ratio <= 5'h00;
            o_memory_skew_ps <= 9'h000;
        end else if (i_ce) begin
            o_spread_mode <= periph_a_q[clock_gen_pkg::PA_SPREAD_HI:clock_gen_pkg::PA_SPREAD_LO];
            o_spread_center <= periph_a_q[clock_gen_pkg::PA_SPREAD_HI];
            o_memory_ratio <= memory_ratio_of(skew_ratio_q[clock_gen_pkg::SR_MEM_HI:clock_gen_pkg::SR_MEM_LO]);
            o_graphics_ratio <= graphics_ratio_of(skew_ratio_q[clock_gen_pkg::SR_GFX_HI:clock_gen_pkg::SR_GFX_LO]);
            o_periph_bus_ratio <= {graphics_ratio_of(skew_ratio_q[clock_gen_pkg::SR_GFX_HI:clock_gen_pkg::SR_GFX_LO]),
                1'b0};
            o_memory_skew_ps <= 9'(clock_gen_pkg::SKEW_STEP_PS)
                * 9'(skew_ratio_q[clock_gen_pkg::SR_SKEW_HI:clock_gen_pkg::SR_SKEW_LO]);
        end
    end

    // read-back; unmapped offsets answer zero
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rd_data <= 8'h00;
        end else if (i_ce && i_rd_en) begin
            unique case (i_addr)
                clock_gen_pkg::OFS_SIGNATURE: o_rd_data <= SIGNATURE;
                clock_gen_pkg::OFS_PERIPH_A: o_rd_data <= periph_a_q;
                clock_gen_pkg::OFS_PERIPH_B: o_rd_data <= periph_b_q;
                clock_gen_pkg::OFS_SKEW_RATIO: o_rd_data <= skew_ratio_q;
                clock_gen_pkg::OFS_WATCHDOG: o_rd_data <= {wd_ctrl_q[7:5], alarm_q, wd_ctrl_q[3:0]};
                default: o_rd_data <= 8'h00;
            endcase
        end
    end

    assign o_watchdog_alarm_flag = alarm_q;
endmodule

`default_nettype wire

// File: tb/clock_gen_properties.sv
`timescale 1ns/1ps
`default_nettype none

module clock_gen_properties #(
    parameter int WD_SECOND_CYCLES = 20,
    parameter logic [7:0] SIGNATURE = 8'h00
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [6:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic [7:0] o_rd_data,
    input wire logic i_power_down_n,
    input wire logic i_shared_pin_in,
    input wire logic o_shared_pin_out,
    input wire logic o_shared_pin_oe,
    input wire logic o_periph_clk_stop_n,
    input wire logic o_power_down,
    input wire logic o_cpu_hiz,
    input wire clock_gen_pkg::clk_enables_s o_clk_en,
    input wire logic [2:0] o_reference_out,
    input wire logic o_fixed_peripheral_clk,
    input wire logic o_spread_center,
    input wire logic [2:0] o_spread_mode,
    input wire logic [3:0] o_graphics_ratio,
    input wire logic [4:0] o_periph_bus_ratio,
    input wire logic [8:0] o_memory_skew_ps,
    input wire logic o_watchdog_alarm_flag
);
    // one clock domain, so clocking and reset are stated once
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // reset pulse is sixteen low cycles, then the pin returns high
    sequence low_run8;
        !o_shared_pin_out [*8];
    endsequence

    pd_from_pin_a: assert property (o_power_down |-> !$past(i_power_down_n))
        else $error("power-down without the pin low");
    hiz_in_pd_a: assert property (o_cpu_hiz |-> o_power_down)
        else $error("high impedance outside power-down");
    // a gate that has been off for two cycles must leave the output low
    fixed_gate_a: assert property (!o_clk_en.fixed_peripheral && $past(!o_clk_en.fixed_peripheral)
        |-> !o_fixed_peripheral_clk)
        else $error("fixed peripheral clock runs while disabled");
    ref_gate_a: assert property ((o_reference_out & ~o_clk_en.reference & ~$past(o_clk_en.reference)) == 3'h0)
        else $error("reference output runs while forced low");
    spread_top_a: assert property (o_spread_center == o_spread_mode[2])
        else $error("spread center not the top mode bit");
    bus_half_a: assert property (o_periph_bus_ratio == {1'b0, o_graphics_ratio} * 5'h02)
        else $error("peripheral bus ratio not twice graphics");
    gfx_codes_a: assert property (o_graphics_ratio inside {4'h0, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA})
        else $error("graphics ratio outside its table");
    skew_steps_a: assert property (o_memory_skew_ps inside {9'h000, 9'h096, 9'h12C, 9'h1C2})
        else $error("skew not a 150 ps step");
    pulse_width_a: assert property ($fell(o_shared_pin_out) |-> low_run8 ##1 low_run8 ##1 o_shared_pin_out)
        else $error("reset pulse width wrong");
    pulse_alarm_a: assert property ($fell(o_shared_pin_out) |-> o_watchdog_alarm_flag && o_shared_pin_oe)
        else $error("reset pulse without alarm or drive");
    alarm_clear_a: assert property (i_wr_en && i_addr == 7'h0C && i_wr_data[3:0] == 4'h0
        |-> ##2 !o_watchdog_alarm_flag)
        else $error("alarm not cleared by zero period");
    stop_pin_a: assert property (!o_periph_clk_stop_n |-> !$past(i_shared_pin_in) && !o_shared_pin_oe)
        else $error("clock stop without pin input mode");
    sig_read_a: assert property (i_rd_en && i_addr == 7'h08 |=> o_rd_data == SIGNATURE)
        else $error("signature read wrong");
endmodule

bind clock_gen_control_regs clock_gen_properties #(.WD_SECOND_CYCLES(WD_SECOND_CYCLES), .SIGNATURE(SIGNATURE))
    i_props (.i_clk, .i_resetn, .i_wr_en, .i_rd_en, .i_addr, .i_wr_data, .o_rd_data, .i_power_down_n,
    .i_shared_pin_in, .o_shared_pin_out, .o_shared_pin_oe, .o_periph_clk_stop_n, .o_power_down, .o_cpu_hiz,
    .o_clk_en, .o_reference_out, .o_fixed_peripheral_clk, .o_spread_center, .o_spread_mode, .o_graphics_ratio,
    .o_periph_bus_ratio, .o_memory_skew_ps, .o_watchdog_alarm_flag);

`default_nettype wire

// File: tb/clock_gen_host.sv
`timescale 1ns/1ps
`default_nettype none

module clock_gen_host (
    input wire logic i_clk,
    input wire logic [7:0] i_rd_data,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [6:0] o_addr,
    output logic [7:0] o_wr_data
);
    // idle bus, address parked away from the mapped bytes
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 7'h7F;
        o_wr_data = 8'hFF;
    end

    // one byte write, held across exactly one taking edge
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_wr_data = (a == clock_gen_pkg::OFS_WATCHDOG) ? (d & 8'hDF) : d;
        o_wr_en = 1'b1;
        @(negedge i_clk);
        o_wr_en = 1'b0;
        o_wr_data = ~o_wr_data;
    endtask

    // one byte read; data is taken one and a half cycles after the taking edge
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_rd_en = 1'b1;
        @(negedge i_clk);
        o_rd_en = 1'b0;
        @(negedge i_clk);
        d = i_rd_data;
    endtask
endmodule

`default_nettype wire

// File: tb/clock_gen_control_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none

module clock_gen_control_regs_bench;
    localparam int SEC = 20;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_wr_en, i_rd_en;
    logic [6:0] i_addr;
    logic [7:0] i_wr_data, o_rd_data, d;
    logic i_power_down_n = 1'b1, i_reference_src = 1'b1, i_src_48m = 1'b1, i_src_24m = 1'b0;
    logic [4:0] i_strap_freq = 5'h11, i_new_freq = 5'h00;
    logic i_freq_change = 1'b0, pin_in = 1'b1;
    logic o_shared_pin_out, o_shared_pin_oe, o_periph_clk_stop_n, o_power_down, o_cpu_true_level;
    logic o_cpu_comp_level, o_cpu_hiz, o_fixed_peripheral_clk, o_selectable_peripheral_clk, o_spread_center;
    clock_gen_pkg::clk_enables_s o_clk_en;
    logic [2:0] o_reference_out, o_spread_mode;
    logic [3:0] o_memory_ratio, o_graphics_ratio;
    logic [4:0] o_periph_bus_ratio, o_freq_sel;
    logic [8:0] o_memory_skew_ps;
    logic o_watchdog_alarm_flag;
    wire logic pin_lvl;
    int n_fail = 0;
    int compares = 0;

    // shared pin: the device drives it only while its enable is high
    assign pin_lvl = o_shared_pin_oe ? o_shared_pin_out : pin_in;
    always #50 i_clk = ~i_clk;

    clock_gen_host i_host (.i_clk, .i_rd_data(o_rd_data), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
        .o_addr(i_addr), .o_wr_data(i_wr_data));

    clock_gen_control_regs #(.WD_SECOND_CYCLES(SEC)) i_dut (.i_clk, .i_resetn, .i_ce(1'b1), .i_wr_en,
        .i_rd_en, .i_addr, .i_wr_data, .o_rd_data, .i_power_down_n, .i_reference_src, .i_src_48m, .i_src_24m,
        .i_strap_freq, .i_freq_change, .i_new_freq, .i_shared_pin_in(pin_lvl), .o_shared_pin_out,
        .o_shared_pin_oe, .o_periph_clk_stop_n, .o_power_down, .o_cpu_true_level, .o_cpu_comp_level,
        .o_cpu_hiz, .o_clk_en, .o_reference_out, .o_fixed_peripheral_clk, .o_selectable_peripheral_clk,
        .o_spread_center, .o_spread_mode, .o_memory_ratio, .o_graphics_ratio, .o_periph_bus_ratio,
        .o_memory_skew_ps, .o_freq_sel, .o_watchdog_alarm_flag);

    task automatic end_sim();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // bounded wait for the reset pulse; n counts cycles spent waiting
    task automatic wait_pulse(output int n);
        n = 0;
        while (o_shared_pin_out !== 1'b0) begin
            tick(1);
            n++;
            if (n > 400) begin
                n_fail++;
                end_sim();
            end
        end
    endtask

    task automatic freq_step(input logic [4:0] f);
        @(negedge i_clk);
        i_new_freq = f;
        i_freq_change = 1'b1;
        @(negedge i_clk);
        i_freq_change = 1'b0;
    endtask

    task automatic t_regs();
        logic [7:0] exp [6];
        exp = '{clock_gen_pkg::SIGNATURE_DEFAULT, 8'hB8, 8'hFF, 8'h00, 8'h80, 8'h00};
        chk(o_freq_sel, 5'h11, "strap at start");
        i_host.wr(7'h08, 8'hA5);
        for (int i = 0; i < 6; i++) begin
            i_host.rd(7'h08 + 7'(i), d);
            chk(d, exp[i], "reset value");
        end
    endtask

    task automatic t_periph_b();
        logic [7:0] v [3];
        v = '{8'h00, 8'h7F, 8'hA5};
        foreach (v[i]) begin
            i_host.wr(7'h0A, v[i]);
            tick(2);
            chk(o_clk_en.memory, v[i][7], "memory enable");
            chk(o_clk_en.bus_link, v[i][3:2], "link enables");
            chk(o_clk_en.graphics, v[i][1:0], "graphics enables");
            chk(o_reference_out, v[i][6:4], "reference gates");
        end
    endtask

    task automatic t_periph_a();
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v = {2'b10, 3'(i) ^ 3'h5, 3'(i)};
            i_host.wr(7'h09, v);
            tick(2);
            chk(o_fixed_peripheral_clk, v[5], "fixed clock");
            chk(o_selectable_peripheral_clk, v[4] & v[3], "selectable clock");
            chk({o_spread_center, o_spread_mode}, {v[2], v[2:0]}, "spread");
        end
    endtask

    task automatic t_power_down();
        i_host.wr(7'h09, 8'hB8);
        i_power_down_n = 1'b0;
        tick(2);
        chk(o_power_down, 1'b0, "pin ignored");
        i_host.wr(7'h09, 8'h38);
        tick(2);
        chk({o_power_down, o_cpu_hiz, o_cpu_true_level, o_cpu_comp_level}, 4'hA, "parked");
        i_host.wr(7'h09, 8'h78);
        tick(2);
        chk({o_power_down, o_cpu_hiz}, 2'h3, "parked hiz");
        i_power_down_n = 1'b1;
        tick(2);
        chk(o_power_down, 1'b0, "power-down left");
        i_host.wr(7'h09, 8'hB8);
    endtask

    task automatic t_ratios();
        logic [3:0] mem [8];
        logic [3:0] gfx [8];
        mem = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};
        gfx = '{4'h0, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hA, 4'hA};
        for (int i = 0; i < 8; i++) begin
            i_host.wr(7'h0B, {3'(i), 3'(7 - i), 2'(i)});
            tick(2);
            chk(o_memory_ratio, mem[i], "memory ratio");
            chk(o_graphics_ratio, gfx[7 - i], "graphics ratio");
            chk(o_periph_bus_ratio, 5'(gfx[7 - i]) * 5'h02, "bus ratio");
            chk(o_memory_skew_ps, 9'(i % 4) * 9'h096, "skew");
        end
    endtask

    task automatic t_watchdog();
        int n;
        i_host.wr(7'h0C, 8'h62);
        freq_step(5'h05);
        freq_step(5'h07);
        chk(o_freq_sel, 5'h07, "software frequency");
        wait_pulse(n);
        chk(n >= 2 * SEC && n <= 2 * SEC + 5, 1'b1, "period timing");
        chk({o_watchdog_alarm_flag, o_freq_sel}, 6'h27, "first expiry");
        tick(17);
        wait_pulse(n);
        chk({o_watchdog_alarm_flag, o_freq_sel}, 6'h25, "revert software");
        // let the running pulse end so the next wait sees a fresh one
        tick(17);
        i_host.wr(7'h0C, 8'h01);
        wait_pulse(n);
        chk(n >= SEC && n <= SEC + 5, 1'b1, "restart on write");
        chk(o_freq_sel, 5'h11, "revert strap");
        // clear well before the next one-second expiry, which would win over the clear
        tick(10);
        i_host.wr(7'h0C, 8'h00);
        i_host.rd(7'h0C, d);
        chk(d, 8'h00, "alarm cleared");
        tick(3 * SEC);
        chk(o_shared_pin_out, 1'b1, "timer off");
        i_host.wr(7'h0C, 8'h80);
        pin_in = 1'b0;
        tick(2);
        chk({o_periph_clk_stop_n, o_shared_pin_oe}, 2'h0, "clock stop input");
        pin_in = 1'b1;
    endtask

    // main sequence: reset for eight cycles, then each scenario in turn
    initial begin
        repeat (8) @(negedge i_clk);
        i_resetn = 1'b1;
        tick(2);
        t_regs();
        t_periph_b();
        t_periph_a();
        t_power_down();
        t_ratios();
        t_watchdog();
        end_sim();
    end
endmodule

`default_nettype wire
